/* verif/epf_enc_model.sv */
// Serial absolute encoder answering the front end's link clock.
// Assumes the link clock idles high; the bench sets pos and bad.
`timescale 1ns/1ps
module epf_enc_model (
    input  logic        aclk, // Clock.
    input  logic        sclk, // Link clock.
    input  logic [23:0] pos,  // Position.
    input  logic        bad,  // Corrupt check.
    output logic        sd,   // Data line.
    output int          nfr   // Frames sent.
);
    logic [34:0] sh;
    logic [25:0] d;
    logic [5:0]  crc;
    int          cnt = 0;
    int          hi = 0;
    assign d = {pos, 2'b00};
    initial sd = 1'b1;
    initial nfr = 0;
    // Shifts ack, start, status, data and inverted check on falling edges.
    always @(negedge sclk) begin
        if (cnt == 0) begin
            crc = 6'h00;
            for (int i = 25; i >= 0; i--)
                crc = {crc[4:0], 1'b0} ^ {4'h0, {2{crc[5] ^ d[i]}}};
            sh = {3'b010, d, ~crc ^ {6{bad}}};
        end
        sd = (cnt < 35) ? sh[34 - cnt] : 1'b0;
        cnt++;
    end
    // Releases the line high once the clock rests, which ends the frame.
    always @(posedge aclk) begin
        hi = sclk ? hi + 1 : 0;
        if (hi == 60 && cnt != 0) begin
            sd = 1'b1;
            cnt = 0;
            nfr++;
        end
    end
endmodule : epf_enc_model

/* verif/epf_frontend_asserts.sv */
// Concurrent checks on the register bus, the link clock and the error flag.
// Assumes it is bound into epf_frontend, whose port names it shares.
`timescale 1ns/1ps
module epf_frontend_asserts (
    input logic        aclk,          // Clock.
    input logic        aresetn,       // Reset.
    input logic        s_axi_awready, // Write ready.
    input logic [1:0]  s_axi_bresp,   // Response.
    input logic        s_axi_bvalid,  // Response valid.
    input logic        s_axi_bready,  // Response ready.
    input logic        s_axi_arvalid, // Read valid.
    input logic        s_axi_arready, // Read ready.
    input logic [31:0] s_axi_rdata,   // Read data.
    input logic        s_axi_rvalid,  // Data valid.
    input logic        s_axi_rready,  // Data ready.
    input logic        ser_clk_out,   // Link clock.
    input logic        enc_error      // Error flag.
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers hold until taken and the write channel reopens afterwards.
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early.");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early.");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered.");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read.");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during write.");
    write_close_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready) else $error("write not closed.");
    error_sticky_a: assert property (
        enc_error |=> enc_error || $rose(s_axi_bvalid)) else $error("error flag lost.");
    link_low_a: assert property ($fell(ser_clk_out) |=>
        !ser_clk_out [*8] ##[1:30] ser_clk_out) else $error("link low half wrong.");
    // Main scenarios.
    cover property ($rose(enc_error));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($fell(ser_clk_out));
endmodule : epf_frontend_asserts
bind epf_frontend epf_frontend_asserts epf_frontend_asserts_inst (.*);

/* verif/epf_frontend_tb.sv */
// Bench for the encoder front end: bus tasks, pin drivers, encoder model.
// Assumes the register offsets of epf_regs.svh.
`timescale 1ns/1ps
`include "epf_regs.svh"
module epf_frontend_tb;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ph = 0;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, bad = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, ser_clk_out, ser_data_in, inc_port_oe, enc_error;
    logic        inc_a_in = 0, inc_b_in = 0, inc_n_in = 0;
    logic [23:0] pos = 24'h100000;
    int          errors = 0, comparisons = 0, nfr, k;
    always #5 aclk = ~aclk;
    epf_frontend epf_frontend_inst (.*);
    epf_enc_model epf_enc_model_inst (.aclk(aclk), .sclk(ser_clk_out), .pos(pos),
        .bad(bad), .sd(ser_data_in), .nfr(nfr));
    task automatic chk(input string s, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic hang();
        errors++;
        print_verdict();
    endtask : hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 99 && !s_axi_bvalid; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        if (k == 99) hang();
        chk("bresp", s_axi_bresp, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 0);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 99 && !s_axi_rvalid; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        if (k == 99) hang();
        chk("rdata", s_axi_rdata, x);
        chk("rresp", s_axi_rresp, e);
    endtask : rd
    // Pin levels hold 13 cycles, above the three the inputs need.
    task automatic pin(input logic va, vb, vn);
        @(posedge aclk);
        {inc_a_in, inc_b_in, inc_n_in} <= {va, vb, vn};
        repeat (12) @(posedge aclk);
    endtask : pin
    task automatic quad(input int c, input logic [1:0] dir);
        repeat (c) begin
            ph = ph + dir;
            pin(ph[0] ^ ph[1], ph[1], 1'b0);
        end
    endtask : quad
    task automatic pl(input int c, input logic [1:0] h, l);
        repeat (c) begin
            pin(h[1], h[0], 1'b0);
            pin(l[1], l[0], 1'b0);
        end
    endtask : pl
    task automatic fr(input int c);
        int f;
        f = nfr + c;
        for (k = 0; k < 20000 && nfr < f; k++) @(posedge aclk);
        if (k == 20000) hang();
    endtask : fr
    // Main sequence: registers, incremental modes, then serial mappings.
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(`EPF_OFS_CTRL, 32'h0);
        rd(`EPF_OFS_FRAME, 32'h0000_c61a);
        rd(`EPF_OFS_GEAR, 32'h0001_0000);
        rd(8'h28, 32'h0, 2'h2);
        wr(`EPF_OFS_SERPOS, 32'h5, 2'h2);
        $display("test registers done");
        quad(8, 2'h1);
        quad(4, 2'h3);
        rd(`EPF_OFS_INCPOS, 32'h4);
        wr(`EPF_OFS_GEAR, 32'h0002_0000);
        wr(`EPF_OFS_CTRL, 32'h08);
        pl(3, 2'b10, 2'b00);
        pl(2, 2'b11, 2'b01);
        rd(`EPF_OFS_INCPOS, 32'h5);
        rd(`EPF_OFS_SETPT, 32'ha);
        pin(0, 0, 0);
        wr(`EPF_OFS_CTRL, 32'h10);
        pl(3, 2'b10, 2'b00);
        pl(1, 2'b01, 2'b00);
        rd(`EPF_OFS_INCPOS, 32'h7);
        wr(`EPF_OFS_CTRL, 32'h90);
        pl(2, 2'b10, 2'b00);
        wr(`EPF_OFS_CTRL, 32'h30);
        pl(2, 2'b10, 2'b00);
        chk("oe", {31'h0, inc_port_oe}, 32'h1);
        rd(`EPF_OFS_INCPOS, 32'h7);
        wr(`EPF_OFS_CTRL, 32'h40);
        pin(0, 0, 1);
        pin(0, 0, 0);
        rd(`EPF_OFS_INCPOS, 32'h0);
        $display("test incremental done");
        wr(`EPF_OFS_CTRL, 32'h01);
        fr(2);
        rd(`EPF_OFS_SERPOS, 32'h0);
        pos <= 24'h0ffffd;
        fr(2);
        rd(`EPF_OFS_SERPOS, 32'hffff_fffd);
        chk("err", {31'h0, enc_error}, 32'h0);
        bad <= 1;
        pos <= 24'h000123;
        fr(2);
        rd(`EPF_OFS_SERPOS, 32'hffff_fffd);
        bad <= 0;
        fr(2);
        chk("err", {31'h0, enc_error}, 32'h1);
        wr(`EPF_OFS_STATUS, 32'h1);
        chk("err", {31'h0, enc_error}, 32'h0);
        rd(`EPF_OFS_SERPOS, 32'hfff0_0123);
        wr(`EPF_OFS_CTRL, 32'h03);
        pos <= 24'h345678;
        fr(2);
        rd(`EPF_OFS_SERPOS, 32'h678);
        rd(`EPF_OFS_SERTURN, 32'h345);
        wr(`EPF_OFS_LINES, 32'd1000);
        wr(`EPF_OFS_CTRL, 32'h05);
        pos <= 24'h001234;
        fr(2);
        rd(`EPF_OFS_SERPOS, 32'h294);
        rd(`EPF_OFS_SERTURN, 32'h4);
        $display("test serial done");
        print_verdict();
    end
endmodule : epf_frontend_tb

/* verilog/epf_frontend.sv */
// Encoder position front end: serial absolute receiver, incremental port
// counter, gear scaling and the AXI4-Lite register slave.
// Assumes aclk at 100 MHz; encoder pins are asynchronous and are synchronised.
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "epf_regs.svh"
module epf_frontend #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,          // System clock.
    input  wire logic              aresetn,       // Synchronous reset, active low.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address.
    input  wire logic              s_axi_awvalid, // Write address valid.
    output logic                   s_axi_awready, // Write address ready.
    input  wire logic [31:0]       s_axi_wdata,   // Write data.
    input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes.
    input  wire logic              s_axi_wvalid,  // Write data valid.
    output logic                   s_axi_wready,  // Write data ready.
    output logic [1:0]             s_axi_bresp,   // Write response.
    output logic                   s_axi_bvalid,  // Write response valid.
    input  wire logic              s_axi_bready,  // Write response ready.
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address.
    input  wire logic              s_axi_arvalid, // Read address valid.
    output logic                   s_axi_arready, // Read address ready.
    output logic [31:0]            s_axi_rdata,   // Read data.
    output logic [1:0]             s_axi_rresp,   // Read response.
    output logic                   s_axi_rvalid,  // Read data valid.
    input  wire logic              s_axi_rready,  // Read data ready.
    output logic                   ser_clk_out,   // Serial link clock to the encoder.
    input  wire logic              ser_data_in,   // Serial data from the encoder.
    input  wire logic              inc_a_in,      // Incremental track A.
    input  wire logic              inc_b_in,      // Incremental track B.
    input  wire logic              inc_n_in,      // Incremental index track.
    output logic                   inc_port_oe,   // Incremental port driven as output.
    output logic                   enc_error      // Sticky encoder error.
);

    localparam logic [6:0]  CRC_GEN   = `EPF_CRC_GEN;
    localparam logic [5:0]  CRC_TAPS  = CRC_GEN[5:0];
    localparam int          RECOV_CYC = (`EPF_RECOV_NS + `EPF_CLK_NS - 1) / `EPF_CLK_NS;
    localparam logic [15:0] RECOV_N   = 16'(RECOV_CYC);

    // Register file.
    epf_pkg::epf_ctrl_s  ctrl;
    epf_pkg::epf_frame_s frame;
    logic [31:0]         lines;
    logic [31:0]         gear;
    logic [15:0]         div;
    logic                seen;

    // Bus holding registers.
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;

    // Synchronised pins.
    logic       slo;
    logic       slo_prev;
    logic [2:0] inc_lvl;
    logic [2:0] inc_prev;

    // Serial receiver state.
    epf_pkg::epf_state_e st;
    logic [15:0]         half_cnt;
    logic [15:0]         wait_cnt;
    logic [5:0]          bit_cnt;
    logic [`EPF_FRAME_MAX-1:0] shreg;
    logic [5:0]          crc;
    logic [5:0]          rx_crc;
    logic [31:0]         pos_raw;
    logic [31:0]         pos_base;

    // Incremental state.
    logic [31:0] inc_pos;
    logic [31:0] rev_pos;
    logic [31:0] setpt;

    epf_pin_sync #(.W(1), .RST(1'b1)) u_ser_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (ser_data_in),
        .level   (slo),
        .prev    (slo_prev)
    );

    epf_pin_sync #(.W(3), .RST(3'h0)) u_inc_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     ({inc_n_in, inc_b_in, inc_a_in}),
        .level   (inc_lvl),
        .prev    (inc_prev)
    );

    // Byte-lane merge of a write into a register.
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (cur & ~m) | (d & m);
    endfunction : merge

    // Write decode: a write goes ahead once address and data are both held.
    wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl  = do_write && aw_addr == ADDR_W'(`EPF_OFS_CTRL);
    wire wr_frame = do_write && aw_addr == ADDR_W'(`EPF_OFS_FRAME);
    wire wr_lines = do_write && aw_addr == ADDR_W'(`EPF_OFS_LINES);
    wire wr_gear  = do_write && aw_addr == ADDR_W'(`EPF_OFS_GEAR);
    wire wr_stat  = do_write && aw_addr == ADDR_W'(`EPF_OFS_STATUS);
    wire wr_div   = do_write && aw_addr == ADDR_W'(`EPF_OFS_DIV);
    wire wr_hit   = wr_ctrl | wr_frame | wr_lines | wr_gear | wr_stat | wr_div;
    wire [31:0] m_ctrl  = merge({24'h0, ctrl}, w_data, w_strb);
    wire [31:0] m_frame = merge({14'h0, frame}, w_data, w_strb);
    wire [31:0] m_div   = merge({16'h0, div}, w_data, w_strb);
    wire        err_clr = wr_stat && w_strb[0] && w_data[`EPF_STAT_ERR];

    // Serial bit timing: a half period of the link clock ends on each tick.
    wire tick      = half_cnt == 16'h0;
    wire toggling  = st == epf_pkg::EPF_S_ACK || st == epf_pkg::EPF_S_START
                  || st == epf_pkg::EPF_S_CDS || st == epf_pkg::EPF_S_DATA
                  || st == epf_pkg::EPF_S_CRC;
    wire sample    = tick && toggling && !ser_clk_out;
    wire crc_fb    = crc[5] ^ slo;
    wire [5:0] next_crc = {crc[4:0], 1'b0} ^ (crc_fb ? CRC_TAPS : 6'h0);
    wire [5:0] last_bit = frame.frame_len - 6'h1;
    wire [5:0] pos_sh   = frame.frame_len - frame.pos_len;
    wire [63:0] pos_m64 = (64'h1 << frame.pos_len) - 64'h1;
    wire [63:0] st_m64  = (64'h1 << frame.st_len) - 64'h1;
    wire [`EPF_FRAME_MAX-1:0] field = shreg >> pos_sh;
    wire [31:0] next_pos = field[31:0] & pos_m64[31:0];
    wire        crc_ok   = ~rx_crc == crc;

    // Serial receiver: the link clock is made here and only position is read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= epf_pkg::EPF_S_IDLE;
            ser_clk_out <= 1'b1;
            half_cnt    <= 16'h0;
            wait_cnt    <= 16'h0;
            bit_cnt     <= 6'h0;
            shreg       <= '0;
            crc         <= 6'h0;
            rx_crc      <= 6'h0;
        end else begin
            half_cnt <= (tick || !toggling) ? div : half_cnt - 16'h1;
            if (toggling && tick) begin
                ser_clk_out <= ~ser_clk_out;
            end else if (!toggling) begin
                ser_clk_out <= 1'b1;
            end
            unique case (st)
                epf_pkg::EPF_S_IDLE: begin
                    wait_cnt <= 16'h0;
                    if (ctrl.ser_en && slo && !ctrl.port_out) begin
                        st <= epf_pkg::EPF_S_ACK;
                    end
                end
                epf_pkg::EPF_S_ACK: begin
                    if (sample && !slo) begin
                        st <= epf_pkg::EPF_S_START;
                    end else if (sample && wait_cnt[7:0] == `EPF_ACK_LIMIT) begin
                        st <= epf_pkg::EPF_S_RECOV;
                    end else if (sample) begin
                        wait_cnt <= wait_cnt + 16'h1;
                    end
                end
                epf_pkg::EPF_S_START: begin
                    if (sample && slo) begin
                        st <= epf_pkg::EPF_S_CDS;
                    end
                end
                epf_pkg::EPF_S_CDS: begin
                    if (sample) begin
                        st      <= epf_pkg::EPF_S_DATA;
                        bit_cnt <= 6'h0;
                        crc     <= 6'h0;
                    end
                end
                epf_pkg::EPF_S_DATA: begin
                    if (sample) begin
                        shreg   <= {shreg[`EPF_FRAME_MAX-2:0], slo};
                        crc     <= next_crc;
                        bit_cnt <= bit_cnt + 6'h1;
                        if (bit_cnt == last_bit) begin
                            st      <= epf_pkg::EPF_S_CRC;
                            bit_cnt <= 6'h0;
                        end
                    end
                end
                epf_pkg::EPF_S_CRC: begin
                    if (sample) begin
                        rx_crc  <= {rx_crc[4:0], slo};
                        bit_cnt <= bit_cnt + 6'h1;
                        if (bit_cnt == 6'h5) begin
                            st <= epf_pkg::EPF_S_DONE;
                        end
                    end
                end
                epf_pkg::EPF_S_DONE: begin
                    st       <= epf_pkg::EPF_S_RECOV;
                    wait_cnt <= 16'h0;
                end
                epf_pkg::EPF_S_RECOV: begin
                    wait_cnt <= wait_cnt + 16'h1;
                    if (wait_cnt >= RECOV_N && slo) begin
                        st <= epf_pkg::EPF_S_IDLE;
                    end
                end
            endcase
        end
    end

    // Frame result: only checked frames update the position.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_raw   <= 32'h0;
            pos_base  <= 32'h0;
            seen      <= 1'b0;
            enc_error <= 1'b0;
        end else begin
            if (st == epf_pkg::EPF_S_DONE && crc_ok) begin
                pos_raw <= next_pos;
                seen    <= 1'b1;
                if (!seen) begin
                    pos_base <= next_pos;
                end
            end
            enc_error <= (st == epf_pkg::EPF_S_DONE && !crc_ok) | (enc_error & ~err_clr);
        end
    end

    // Position mapping. The analogue track of the primary port has no input
    // here, so only the serial frame feeds it.
    wire [5:0]  rel_sh   = 6'h20 - frame.pos_len;
    wire [31:0] rel_diff = (pos_raw - pos_base) << rel_sh;
    wire [31:0] rel_pos  = 32'($signed(rel_diff) >>> rel_sh);
    wire [31:0] rot_st   = pos_raw & st_m64[31:0];
    wire [31:0] rot_mt   = pos_raw >> frame.st_len;
    wire [31:0] lin_div  = (lines == 32'h0) ? 32'h1 : lines;
    wire [31:0] abs_st   = pos_raw % lin_div;
    wire [31:0] abs_mt   = pos_raw / lin_div;
    wire [31:0] ser_pos  = (ctrl.map == epf_pkg::EPF_MAP_ROTATIVE) ? rot_st
                         : (ctrl.map == epf_pkg::EPF_MAP_ABS_LIN) ? abs_st : rel_pos;
    wire [31:0] ser_turn = (ctrl.map == epf_pkg::EPF_MAP_ROTATIVE) ? rot_mt
                         : (ctrl.map == epf_pkg::EPF_MAP_ABS_LIN) ? abs_mt : 32'h0;

    // Incremental step decode for the three counting modes.
    wire a_rise  = inc_lvl[0] & ~inc_prev[0];
    wire b_rise  = inc_lvl[1] & ~inc_prev[1];
    wire n_rise  = inc_lvl[2] & ~inc_prev[2];
    wire q_step  = (inc_lvl[0] ^ inc_prev[0]) ^ (inc_lvl[1] ^ inc_prev[1]);
    wire q_up    = ~(inc_prev[0] ^ inc_lvl[1]);
    wire cnt_en  = !ctrl.ignore_cnt && !ctrl.port_out;
    wire is_quad = ctrl.inc_mode == epf_pkg::EPF_INC_QUAD;
    wire is_pd   = ctrl.inc_mode == epf_pkg::EPF_INC_PULSE_DIR;
    wire step    = cnt_en && (is_quad ? q_step
                 : is_pd ? a_rise
                 : (a_rise ^ b_rise));
    wire step_up = is_quad ? q_up : is_pd ? ~inc_lvl[1] : a_rise;
    wire [31:0] incs    = {lines[29:0], 2'b00};
    wire [31:0] incs_m1 = incs - 32'h1;
    wire        index   = cnt_en && is_quad && ctrl.index_en && n_rise;
    wire        near_lo = rev_pos < {1'b0, incs[31:1]};
    wire [63:0] prod    = {{32{inc_pos[31]}}, inc_pos} * {32'h0, gear};

    // Incremental counter and index correction.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inc_pos <= 32'h0;
            rev_pos <= 32'h0;
        end else if (index) begin
            // Snap to the nearest revolution boundary; relies on exact counts.
            inc_pos <= near_lo ? inc_pos - rev_pos : inc_pos + (incs - rev_pos);
            rev_pos <= 32'h0;
        end else if (step && step_up) begin
            inc_pos <= inc_pos + 32'h1;
            rev_pos <= (rev_pos >= incs_m1) ? 32'h0 : rev_pos + 32'h1;
        end else if (step) begin
            inc_pos <= inc_pos - 32'h1;
            rev_pos <= (rev_pos == 32'h0) ? incs_m1 : rev_pos - 32'h1;
        end
    end

    // Gear-scaled setpoint, gear in 16.16 fixed point.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setpt <= 32'h0;
        end else begin
            setpt <= prod[47:16];
        end
    end

    // Configuration registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl  <= epf_pkg::epf_ctrl_s'(`EPF_CTRL_RST);
            frame <= epf_pkg::epf_frame_s'(`EPF_FRAME_RST);
            lines <= `EPF_LINES_RST;
            gear  <= `EPF_GEAR_RST;
            div   <= `EPF_DIV_RST;
        end else begin
            if (wr_ctrl) ctrl <= epf_pkg::epf_ctrl_s'(m_ctrl[`EPF_CTRL_W-1:0]);
            if (wr_frame) frame <= epf_pkg::epf_frame_s'(m_frame[`EPF_FRAME_W-1:0]);
            if (wr_lines) lines <= merge(lines, w_data, w_strb);
            if (wr_gear) gear <= merge(gear, w_data, w_strb);
            if (wr_div) div <= m_div[15:0];
        end
    end

    assign inc_port_oe = ctrl.port_out;

    // Read decode.
    wire [ADDR_W-1:0] ra = s_axi_araddr;
    wire [31:0] stat_word = {29'h0, st != epf_pkg::EPF_S_IDLE, seen, enc_error};
    wire [31:0] rd_word =
        (ra == ADDR_W'(`EPF_OFS_CTRL))    ? {24'h0, ctrl}  :
        (ra == ADDR_W'(`EPF_OFS_FRAME))   ? {14'h0, frame} :
        (ra == ADDR_W'(`EPF_OFS_LINES))   ? lines          :
        (ra == ADDR_W'(`EPF_OFS_GEAR))    ? gear           :
        (ra == ADDR_W'(`EPF_OFS_STATUS))  ? stat_word      :
        (ra == ADDR_W'(`EPF_OFS_SERPOS))  ? ser_pos        :
        (ra == ADDR_W'(`EPF_OFS_SERTURN)) ? ser_turn       :
        (ra == ADDR_W'(`EPF_OFS_INCPOS))  ? inc_pos        :
        (ra == ADDR_W'(`EPF_OFS_SETPT))   ? setpt          :
        (ra == ADDR_W'(`EPF_OFS_DIV))     ? {16'h0, div}   : 32'h0;
    wire rd_hit = ra[1:0] == 2'b00 && ra <= ADDR_W'(`EPF_OFS_DIV);

    // AXI4-Lite write channel handshakes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_addr       <= '0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel: data are captured when the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : epf_frontend

/* verilog/epf_pin_sync.sv */
// Two-stage synchroniser for a group of pins, with a delayed copy for edges.
// Assumes the pins are asynchronous to aclk.
`timescale 1ns/1ps
module epf_pin_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         aclk,    // System clock.
    input  wire logic         aresetn, // Synchronous reset, active low.
    input  wire logic [W-1:0] pin,     // Raw pins.
    output logic      [W-1:0] level,   // Synchronised level.
    output logic      [W-1:0] prev     // Level one cycle earlier.
);

    logic [W-1:0] meta;

    // The first stage is read only by the second stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta  <= RST;
            level <= RST;
            prev  <= RST;
        end else begin
            meta  <= pin;
            level <= meta;
            prev  <= level;
        end
    end

endmodule : epf_pin_sync

/* verilog/epf_pkg.sv */
// Types shared by the encoder position front end.
// Assumes nothing beyond a SystemVerilog compiler.
package epf_pkg;

    // Position mapping of the serial frame.
    typedef enum logic [1:0] {
        EPF_MAP_REL_LIN = 2'h0,
        EPF_MAP_ROTATIVE = 2'h1,
        EPF_MAP_ABS_LIN = 2'h2
    } epf_map_e;

    // Counting modes of the incremental port.
    typedef enum logic [1:0] {
        EPF_INC_QUAD = 2'h0,
        EPF_INC_PULSE_DIR = 2'h1,
        EPF_INC_UP_DOWN = 2'h2
    } epf_inc_mode_e;

    // Serial receiver states, Gray coded along the frame path.
    typedef enum logic [2:0] {
        EPF_S_IDLE  = 3'h0,
        EPF_S_ACK   = 3'h1,
        EPF_S_START = 3'h3,
        EPF_S_CDS   = 3'h2,
        EPF_S_DATA  = 3'h6,
        EPF_S_CRC   = 3'h7,
        EPF_S_DONE  = 3'h5,
        EPF_S_RECOV = 3'h4
    } epf_state_e;

    // Control word.
    typedef struct packed {
        logic          ignore_cnt;
        logic          index_en;
        logic          port_out;
        epf_inc_mode_e inc_mode;
        epf_map_e      map;
        logic          ser_en;
    } epf_ctrl_s;

    // Frame layout word.
    typedef struct packed {
        logic [5:0] st_len;
        logic [5:0] pos_len;
        logic [5:0] frame_len;
    } epf_frame_s;

endpackage : epf_pkg

/* verilog/epf_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// encoder position front end.
// Assumes a 100 MHz register clock and 32-bit AXI4-Lite words.
`ifndef EPF_REGS_SVH
`define EPF_REGS_SVH

// Byte offsets of the register words.
`define EPF_OFS_CTRL    8'h00
`define EPF_OFS_FRAME   8'h04
`define EPF_OFS_LINES   8'h08
`define EPF_OFS_GEAR    8'h0c
`define EPF_OFS_STATUS  8'h10
`define EPF_OFS_SERPOS  8'h14
`define EPF_OFS_SERTURN 8'h18
`define EPF_OFS_INCPOS  8'h1c
`define EPF_OFS_SETPT   8'h20
`define EPF_OFS_DIV     8'h24

// Field widths of the control and frame layout words, and status bit positions.
`define EPF_CTRL_W      8
`define EPF_FRAME_W     18
`define EPF_STAT_ERR    0
`define EPF_STAT_SEEN   1
`define EPF_STAT_BUSY   2

// Reset values.
`define EPF_CTRL_RST    8'h00
`define EPF_FRAME_RST   18'h0c61a
`define EPF_LINES_RST   32'h0000_0400
`define EPF_GEAR_RST    32'h0001_0000
`define EPF_DIV_RST     16'h0019

// Serial link limits and the check polynomial.
`define EPF_FRAME_MAX   40
`define EPF_CRC_GEN     7'h43
`define EPF_ACK_LIMIT   8'h40
`define EPF_CLK_NS      10
`define EPF_RECOV_NS    20000

`endif
